// ---- hw/twrs_pkg.sv ----
// Shared constants and types of the two-wire register port, both ends.
package twrs_pkg;

    // ---------------------------------------------------------------
    // Register space
    // ---------------------------------------------------------------
    localparam int STORE_COUNT = 18;
    localparam int REG_COUNT = 19;
    localparam logic [4:0] PTR_IDX = 5'h12;
    localparam logic [4:0] WRAP_IDX = 5'h00;
    localparam int RAB_RW_BIT = 7;
    localparam int RAB_STEP_BIT = 6;
    localparam int RAB_IDX_MSB = 4;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_GAIN = 8'h08;
    localparam logic [7:0] RST_KEY_HI = 8'h40;
    localparam logic [7:0] RST_KEY_LO = 8'h20;
    localparam logic [7:0] RST_GKEY_HI = 8'h07;
    localparam logic [7:0] RST_PLL_A = 8'h33;
    localparam logic [7:0] RST_PLL_B = 8'h1e;

    function automatic logic [7:0] twrs_reset_val(input int idx);
        logic [7:0] v;
        v = RST_ZERO;
        case (idx)
            4, 5, 6: v = RST_GAIN;
            7, 10, 11: v = RST_KEY_HI;
            8, 12: v = RST_KEY_LO;
            9: v = RST_GKEY_HI;
            13: v = RST_PLL_A;
            14: v = RST_PLL_B;
            default: v = RST_ZERO;
        endcase
        return v;
    endfunction

    typedef enum logic [4:0] {
        D_IDLE = 5'b00001,
        D_RAB = 5'b00010,
        D_WDATA = 5'b00100,
        D_RDATA = 5'b01000,
        D_HALT = 5'b10000
    } twrs_dstate_e;

    // ---------------------------------------------------------------
    // Master side: timing and command port
    // ---------------------------------------------------------------
    localparam int CLK_NS = 8;
    localparam int LINK_KBPS = 400;
    localparam int QTR_NS = 1000000 / (LINK_KBPS * 4);
    localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [1:0] HOST_CMD_OFS = 2'h0;
    localparam logic [1:0] HOST_DATA_OFS = 2'h1;
    localparam logic [1:0] HOST_STAT_OFS = 2'h2;
    localparam logic [1:0] HOST_SEL_OFS = 2'h3;
    localparam int CMD_LAST_BIT = 2;

    typedef enum logic [1:0] {
        C_START = 2'h0,
        C_STOP = 2'h1,
        C_WRITE = 2'h2,
        C_READ = 2'h3
    } twrs_cmd_e;

    typedef enum logic [1:0] {
        H_IDLE = 2'b01,
        H_RUN = 2'b10
    } twrs_hstate_e;

endpackage

// ---- hw/twrs_if.sv ----
// Two-wire link between the register slave and its master.
`timescale 1ns/10ps
interface twrs_if;
    logic cs;
    logic scl;
    logic sda;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic host_sda_o;
    logic host_sda_oe;

    // Open-drain data line: any enabled low driver wins.
    assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

    modport device (
        input cs,
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe
    );

    modport host (
        output cs,
        output scl,
        input sda,
        output host_sda_o,
        output host_sda_oe
    );
endinterface

// ---- hw/twrs_dev.sv ----
// Register slave end of the two-wire programming port.
// Functional notes
// - Master raises select before start, drops after stop.
// - Start and stop: data edge while clock high.
// - Data changes only while clock is low.
// - First byte: direction, step flag, 5-bit index.
// - Direction one reads, zero writes.
// - Stepped write increments pointer after storing.
// - Stepped read pre-increments, first read unmodified.
// - Alternating write keeps pointer until new address.
// - Alternating read never alters pointer before loading.
// - Master clocks ack and releases data line.
// - Slave pulls data low for each written byte.
// - Alternating write: address, data, address again.
// - Stepped write at 12h takes new start address.
// - Start or stop ends any stepped sequence.
// - Master makes the clock; slave never drives it.
// - Works up to 400 kbit/s.
// - Lines only pulled low or released; the master drives the clock line both high and low.
// - Master nacks last read byte; slave releases.
// - Repeated start between read address and read data.
// - Stepped read wraps from 12h to 00h.
// - Nineteen byte-wide registers reachable serially.
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
module twrs_dev
    import twrs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    twrs_if.device link,
    output logic [STORE_COUNT*8-1:0] ctrl_regs,
    output logic [4:0] reg_pointer
);

    // ---------------------------------------------------------------
    // Pin synchronisers and glitch filter
    // ---------------------------------------------------------------
    logic [2:0] scl_s_q;
    logic [2:0] sda_s_q;
    logic [2:0] cs_s_q;
    logic scl_q;
    logic sda_q;
    logic cs_q;
    logic scl_p_q;
    logic sda_p_q;
    wire scl_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_q;
    wire sda_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_q;
    wire cs_d = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            cs_s_q <= 3'h0;
        end else if (ce) begin
            scl_s_q <= {scl_s_q[1:0], link.scl};
            sda_s_q <= {sda_s_q[1:0], link.sda};
            cs_s_q <= {cs_s_q[1:0], link.cs};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            cs_q <= 1'b0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else if (ce) begin
            scl_q <= scl_d;
            sda_q <= sda_d;
            cs_q <= cs_d;
            scl_p_q <= scl_q;
            sda_p_q <= sda_q;
        end
    end

    // ---------------------------------------------------------------
    // Bus conditions
    // ---------------------------------------------------------------
    wire scl_hold = scl_q & scl_p_q;
    wire scl_rise = scl_q & ~scl_p_q;
    wire scl_fall = ~scl_q & scl_p_q;
    wire start_ev = cs_q & scl_hold & sda_p_q & ~sda_q;
    wire stop_ev = cs_q & scl_hold & ~sda_p_q & sda_q;

    // ---------------------------------------------------------------
    // Transfer state
    // ---------------------------------------------------------------
    twrs_dstate_e st_q;
    logic [3:0] cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [4:0] ptr_q;
    logic step_q;
    logic pend_q;
    logic oe_q;
    logic [7:0] regs_q [STORE_COUNT];

    wire byte_end = scl_fall & (cnt_q == ACK_SLOT);
    wire at_ptr = (ptr_q == PTR_IDX);
    wire [4:0] ptr_inc = at_ptr ? WRAP_IDX : ptr_q + 5'h01;
    wire [4:0] ptr_nxt = step_q ? ptr_inc : ptr_q;
    wire [4:0] sel_idx = start_ev ? ptr_q : ptr_nxt;
    wire wr_data = byte_end & (st_q == D_WDATA) & ~at_ptr;
    wire tx_bit = tx_q[~cnt_q[2:0]];
    wire ack_own = (st_q == D_RAB) | (st_q == D_WDATA);

    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (sel_idx == PTR_IDX) begin
            rd_byte = {3'h0, sel_idx};
        end else if (sel_idx < 5'(STORE_COUNT)) begin
            rd_byte = regs_q[sel_idx];
        end
    end

    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < STORE_COUNT; gi++) begin : g_reg
            wire wr_hit = wr_data & (ptr_q == 5'(gi));
            always_ff @(posedge clk) begin
                if (rst) begin
                    regs_q[gi] <= twrs_reset_val(gi);
                end else if (ce && wr_hit) begin
                    regs_q[gi] <= rx_q;
                end
            end
            assign ctrl_regs[gi*8 +: 8] = regs_q[gi];
        end
    endgenerate

    // ---------------------------------------------------------------
    // Byte engine
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= D_IDLE;
            cnt_q <= 4'h0;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= WRAP_IDX;
            step_q <= 1'b0;
            pend_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (ce) begin
            if (!cs_q) begin
                st_q <= D_IDLE;
                cnt_q <= 4'h0;
                pend_q <= 1'b0;
                oe_q <= 1'b0;
            end else if (start_ev) begin
                cnt_q <= 4'h0;
                oe_q <= 1'b0;
                pend_q <= 1'b0;
                if (pend_q) begin
                    st_q <= D_RDATA;
                    tx_q <= rd_byte;
                end else begin
                    st_q <= D_RAB;
                end
            end else if (stop_ev) begin
                st_q <= D_IDLE;
                pend_q <= 1'b0;
                oe_q <= 1'b0;
            end else if (scl_rise) begin
                if (cnt_q != ACK_SLOT) begin
                    rx_q <= {rx_q[6:0], sda_q};
                    cnt_q <= cnt_q + 4'h1;
                end else begin
                    cnt_q <= 4'h0;
                    if (st_q == D_RDATA) begin
                        if (sda_q) begin
                            st_q <= D_HALT;
                        end else begin
                            ptr_q <= ptr_nxt;
                            tx_q <= rd_byte;
                        end
                    end
                end
            end else if (scl_fall) begin
                if (byte_end) begin
                    oe_q <= ack_own;
                    case (st_q)
                        D_RAB: begin
                            ptr_q <= rx_q[RAB_IDX_MSB:0];
                            step_q <= rx_q[RAB_STEP_BIT];
                            if (rx_q[RAB_RW_BIT]) begin
                                pend_q <= 1'b1;
                                st_q <= D_HALT;
                            end else begin
                                st_q <= D_WDATA;
                            end
                        end
                        D_WDATA: begin
                            if (at_ptr) begin
                                ptr_q <= rx_q[RAB_IDX_MSB:0];
                            end else if (step_q) begin
                                ptr_q <= ptr_inc;
                            end
                            if (!step_q) begin
                                st_q <= D_RAB;
                            end
                        end
                        default: begin
                            st_q <= st_q;
                        end
                    endcase
                end else if (st_q == D_RDATA) begin
                    oe_q <= ~tx_bit;
                end else begin
                    oe_q <= 1'b0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = oe_q;
    assign reg_pointer = ptr_q;

endmodule

// ---- hw/twrs_host.sv ----
// Master end of the two-wire programming port with a command port.
`timescale 1ns/10ps
module twrs_host
    import twrs_pkg::*;
#(
    parameter int QTR = QTR_CYC
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    twrs_if.host link,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [7:0] rdata
);

    generate
        if (QTR < 8 || QTR > 65535) begin : g_bad_qtr
            $error("Quarter bit time out of range.");
        end
    endgenerate

    // ---------------------------------------------------------------
    // Data line sampler
    // ---------------------------------------------------------------
    logic [2:0] sda_s_q;
    logic sda_q;
    wire sda_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            sda_s_q <= 3'h7;
            sda_q <= 1'b1;
        end else if (ce) begin
            sda_s_q <= {sda_s_q[1:0], link.sda};
            sda_q <= sda_d;
        end
    end

    // ---------------------------------------------------------------
    // Command port
    // ---------------------------------------------------------------
    twrs_hstate_e st_q;
    twrs_cmd_e kind_q;
    logic last_q;
    logic [3:0] bit_q;
    logic [1:0] qtr_q;
    logic [15:0] tmr_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic nack_q;
    logic sel_q;
    logic act_q;
    logic scl_q;
    logic oe_q;
    logic [7:0] rdata_q;

    wire idle = (st_q == H_IDLE);
    wire cmd_wr = we & (addr == HOST_CMD_OFS) & idle;
    wire is_start = (twrs_cmd_e'(wdata[1:0]) == C_START);
    wire cmd_go = cmd_wr & (~is_start | sel_q);
    wire sel_wr = we & (addr == HOST_SEL_OFS) & idle & ~act_q;
    wire dat_wr = we & (addr == HOST_DATA_OFS) & idle;
    wire is_byte = (kind_q == C_WRITE) | (kind_q == C_READ);
    wire at_ack = (bit_q == ACK_SLOT);
    wire tick = (tmr_q == 16'(QTR - 1));
    wire step_done = ~is_byte | at_ack;

    logic bit_val;
    logic val_a;
    logic val_b;
    always_comb begin
        if (at_ack) begin
            bit_val = (kind_q == C_READ) ? last_q : 1'b1;
        end else begin
            bit_val = (kind_q == C_READ) ? 1'b1 : tx_q[~bit_q[2:0]];
        end
        val_a = bit_val;
        val_b = bit_val;
        if (kind_q == C_START) begin
            val_a = 1'b1;
            val_b = 1'b0;
        end else if (kind_q == C_STOP) begin
            val_a = 1'b0;
            val_b = 1'b1;
        end
    end

    wire [7:0] stat = {4'h0, act_q, sel_q, nack_q, ~idle};

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
            sel_q <= 1'b0;
            tx_q <= 8'h00;
        end else if (ce) begin
            if (sel_wr) begin
                sel_q <= wdata[0];
            end
            if (dat_wr) begin
                tx_q <= wdata;
            end
            if (!re) begin
                rdata_q <= 8'h00;
            end else if (addr == HOST_DATA_OFS) begin
                rdata_q <= rx_q;
            end else if (addr == HOST_STAT_OFS) begin
                rdata_q <= stat;
            end else if (addr == HOST_SEL_OFS) begin
                rdata_q <= {7'h00, sel_q};
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    // ---------------------------------------------------------------
    // Bit engine: four quarters per step
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= H_IDLE;
            kind_q <= C_STOP;
            last_q <= 1'b0;
            bit_q <= 4'h0;
            qtr_q <= 2'h0;
            tmr_q <= 16'h0000;
            rx_q <= 8'h00;
            nack_q <= 1'b0;
            act_q <= 1'b0;
            scl_q <= 1'b1;
            oe_q <= 1'b0;
        end else if (ce) begin
            if (idle) begin
                tmr_q <= 16'h0000;
                qtr_q <= 2'h0;
                bit_q <= 4'h0;
                if (cmd_go) begin
                    st_q <= H_RUN;
                    kind_q <= twrs_cmd_e'(wdata[1:0]);
                    last_q <= wdata[CMD_LAST_BIT];
                end
            end else if (!tick) begin
                tmr_q <= tmr_q + 16'h0001;
            end else begin
                tmr_q <= 16'h0000;
                qtr_q <= qtr_q + 2'h1;
                case (qtr_q)
                    2'h0: scl_q <= 1'b0;
                    2'h1: oe_q <= ~val_a;
                    2'h2: scl_q <= 1'b1;
                    default: begin
                        oe_q <= ~val_b;
                        if (is_byte && !at_ack) begin
                            rx_q <= {rx_q[6:0], sda_q};
                        end
                        if (is_byte && at_ack) begin
                            nack_q <= sda_q;
                        end
                        if (step_done) begin
                            st_q <= H_IDLE;
                        end else begin
                            bit_q <= bit_q + 4'h1;
                        end
                        if (kind_q == C_START) begin
                            act_q <= 1'b1;
                        end else if (kind_q == C_STOP) begin
                            act_q <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    assign link.cs = sel_q;
    assign link.scl = scl_q;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = oe_q;
    assign rdata = rdata_q;

endmodule

// ---- verif/twrs_sva.sv ----
// Concurrent checks on the two-wire link between master and slave.
`timescale 1ns/10ps
module twrs_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe
);
    // ---------------------------------------------------------------
    // Helper logic: framing and bit count seen on the wire
    // ---------------------------------------------------------------
    logic scl_q;
    logic sda_q;
    logic idle_q;
    logic rab_q;
    logic wr_q;
    logic [3:0] cnt_q;
    wire start_w = scl && scl_q && sda_q && !sda;
    wire stop_w = scl && scl_q && !sda_q && sda;
    wire rise_w = scl && !scl_q;
    wire fall_w = !scl && scl_q;
    wire hi_w = scl && scl_q;
    wire cnt_top_w = cnt_q == 4'h9;

    always_ff @(posedge clk) begin
        scl_q <= rst ? 1'b1 : scl;
        sda_q <= rst ? 1'b1 : sda;
    end

    always_ff @(posedge clk) begin
        if (rst || start_w) begin
            cnt_q <= 4'h0;
        end else if (rise_w) begin
            cnt_q <= cnt_top_w ? 4'h1 : cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || stop_w) begin
            idle_q <= 1'b1;
        end else if (start_w) begin
            idle_q <= 1'b0;
        end
    end

    // The byte after a start that follows a stop is always an address.
    always_ff @(posedge clk) begin
        if (rst) begin
            rab_q <= 1'b0;
        end else if (start_w) begin
            rab_q <= idle_q;
        end else if (fall_w && cnt_top_w) begin
            rab_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || stop_w) begin
            wr_q <= 1'b0;
        end else if (rise_w && rab_q && cnt_q == 4'h0) begin
            wr_q <= !sda;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence

    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence

    sequence s_ack_hi;
        hi_w && cnt_top_w;
    endsequence

    AST_CS_IDLE: assert property ((!cs) [*4] |-> !dev_sda_oe)
        else $error("slave drives data while deselected");
    AST_LOW_ONLY: assert property (dev_sda_oe |-> !dev_sda_o)
        else $error("slave drives data line high");
    AST_CHANGE_LOW: assert property (
        $changed(dev_sda_oe) |-> !scl && !$past(scl))
        else $error("slave data changed while clock high");
    AST_RAB_ACK: assert property (
        s_ack_hi ##0 rab_q |-> dev_sda_oe && !sda)
        else $error("address byte not acknowledged");
    AST_WRITE_ACK: assert property (
        s_ack_hi ##0 wr_q |-> dev_sda_oe)
        else $error("written byte not acknowledged");
    AST_WRITE_QUIET: assert property (
        hi_w && wr_q && !cnt_top_w |-> !dev_sda_oe)
        else $error("slave drives during a written data bit");
    AST_START_QUIET: assert property (s_start |-> (!dev_sda_oe) [*8])
        else $error("slave drives after a start");
    AST_STOP_QUIET: assert property (s_stop |=> (!dev_sda_oe) [*8])
        else $error("slave drives after a stop");
    AST_NACK_RELEASE: assert property ($fell(scl) && cnt_top_w
        && !wr_q && !rab_q && $past(sda) |-> (!dev_sda_oe) [*8])
        else $error("slave kept driving after a refused read byte");
endmodule

// ---- verif/twrs_tb.sv ----
// Self-checking bench for both ends of the two-wire register port.
`timescale 1ns/10ps
module testbench;
    import twrs_pkg::*;

    localparam int QTR_TB = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [7:0] rdata;
    logic [STORE_COUNT*8-1:0] ctrl_regs;
    logic [4:0] reg_pointer;
    logic [7:0] st;
    logic [7:0] dflt [18];
    int err_total = 0;
    int checks_done = 0;

    twrs_if link_i ();
    twrs_dev twrs_dev_i (.clk(clk), .rst(rst), .ce(ce),
        .link(link_i.device), .ctrl_regs(ctrl_regs),
        .reg_pointer(reg_pointer));
    twrs_host #(.QTR(QTR_TB)) twrs_host_i (.clk(clk), .rst(rst), .ce(ce),
        .link(link_i.host), .addr(addr), .wdata(wdata), .we(we), .re(re),
        .rdata(rdata));
    twrs_sva twrs_sva_i (.clk(clk), .rst(rst), .cs(link_i.cs),
        .scl(link_i.scl), .sda(link_i.sda), .dev_sda_o(link_i.dev_sda_o),
        .dev_sda_oe(link_i.dev_sda_oe));

    always #4 clk = ~clk;

    // ---------------------------------------------------------------
    // Access tasks
    // ---------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Issues a command and polls busy under a bound.
    task automatic cmd(input logic [7:0] c);
        int n;
        wr(HOST_CMD_OFS, c);
        n = 0;
        st = 8'h01;
        while (st[0] !== 1'b0) begin
            rd(HOST_STAT_OFS, st);
            n++;
            if (n > 3000) begin
                err_total++;
                $display("ERROR %0t command never finished", $time);
                report_and_stop();
            end
        end
    endtask

    task automatic wbyte(input logic [7:0] b);
        wr(HOST_DATA_OFS, b);
        cmd({6'h00, C_WRITE});
        check({7'h00, st[1]}, 8'h00);
    endtask

    task automatic rbyte(input logic last, input logic [7:0] exp);
        logic [7:0] got;
        cmd({5'h00, last, C_READ});
        rd(HOST_DATA_OFS, got);
        check(got, exp);
    endtask

    task automatic reg_is(input int i, input logic [7:0] e);
        check(ctrl_regs[8*i +: 8], e);
    endtask

    task automatic ptr_is(input logic [7:0] e);
        check({3'h0, reg_pointer}, e);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        dflt = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h08, 8'h08, 8'h40,
            8'h20, 8'h07, 8'h40, 8'h40, 8'h20, 8'h33, 8'h1e, 8'h00, 8'h00,
            8'h00};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < STORE_COUNT; i++) begin
            reg_is(i, dflt[i]);
        end
        ptr_is(8'h00);
        wr(HOST_SEL_OFS, 8'h01);
        rd(HOST_STAT_OFS, st);
        check({7'h00, st[2]}, 8'h01);
        // Alternating writes to registers 3 and 7.
        cmd({6'h00, C_START});
        wbyte(8'h03);
        wbyte(8'ha5);
        ptr_is(8'h03);
        wbyte(8'h07);
        wbyte(8'h5a);
        cmd({6'h00, C_STOP});
        reg_is(3, 8'ha5);
        reg_is(7, 8'h5a);
        ptr_is(8'h07);
        // Stepped write over the top, reload, then a restart ends it.
        cmd({6'h00, C_START});
        wbyte(8'h50);
        wbyte(8'h11);
        wbyte(8'h22);
        ptr_is(8'h12);
        wbyte(8'h00);
        ptr_is(8'h00);
        wbyte(8'h33);
        ptr_is(8'h01);
        cmd({6'h00, C_START});
        wbyte(8'h05);
        wbyte(8'h44);
        cmd({6'h00, C_STOP});
        reg_is(16, 8'h11);
        reg_is(17, 8'h22);
        reg_is(0, 8'h33);
        reg_is(1, 8'h00);
        reg_is(5, 8'h44);
        // Stepped read that wraps past the pointer register.
        cmd({6'h00, C_START});
        wbyte(8'hd0);
        cmd({6'h00, C_START});
        rbyte(1'b0, 8'h11);
        rbyte(1'b0, 8'h22);
        rbyte(1'b0, 8'h12);
        rbyte(1'b1, 8'h33);
        cmd({6'h00, C_STOP});
        ptr_is(8'h00);
        // Alternating reads keep the pointer.
        cmd({6'h00, C_START});
        wbyte(8'h87);
        cmd({6'h00, C_START});
        rbyte(1'b0, 8'h5a);
        rbyte(1'b1, 8'h5a);
        cmd({6'h00, C_START});
        wbyte(8'h83);
        cmd({6'h00, C_START});
        rbyte(1'b1, 8'ha5);
        cmd({6'h00, C_STOP});
        ptr_is(8'h03);
        wr(HOST_SEL_OFS, 8'h00);
        rd(HOST_STAT_OFS, st);
        check({7'h00, st[2]}, 8'h00);
        // A start without select is refused; a bare byte gets no ack.
        cmd({6'h00, C_START});
        check({7'h00, st[3]}, 8'h00);
        wr(HOST_DATA_OFS, 8'h0a);
        cmd({6'h00, C_WRITE});
        check({7'h00, st[1]}, 8'h01);
        repeat (20) @(posedge clk);
        ptr_is(8'h03);
        report_and_stop();
    end
endmodule
